// [verilog/rvm_top.sv]
// Reset and interrupt vector map with protected table relocation
`timescale 1ns/1ps

module rvm_top (
  input wire logic ref_clk_i, // Core clock, 10 MHz
  input wire logic rst_i, // Asynchronous reset, active high
  input wire logic ce_i, // Clock enable, freezes all state when low
  input wire logic boot_reset_select_fuse_i, // Boot-reset fuse pin, 0 = programmed
  input wire logic [rvm_pkg::ADDR_W-1:0] boot_start_i, // Boot section start word address
  input wire logic ctrl_wr_i, // Core writes the core control register
  input wire logic [rvm_pkg::CTRL_W-1:0] ctrl_wdata_i, // Written select and unlock bits
  input wire logic instr_done_i, // Core finished one instruction
  input wire logic global_en_i, // Global interrupt enable of the core
  input wire logic [rvm_pkg::IRQ_COUNT-1:0] irq_pend_i, // Pending sources, vectors 2..26
  input wire logic irq_ack_i, // Core takes the offered vector
  output logic [rvm_pkg::ADDR_W-1:0] reset_addr_o, // Program address after reset
  output logic [rvm_pkg::ADDR_W-1:0] vec_base_o, // Start of the interrupt table
  output logic irq_valid_o, // A vector is offered
  output logic [rvm_pkg::VEC_NUM_W-1:0] irq_num_o, // Offered vector number
  output logic [rvm_pkg::ADDR_W-1:0] irq_addr_o, // Offered vector program address
  output logic irq_hold_o, // Interrupts held off by the change sequence
  output logic vector_table_select_o, // Read back of the select bit
  output logic vector_change_unlock_o // Read back of the unlock bit
);
  import rvm_pkg::*;

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  // Fuse and boot start are static straps, so a two-stage capture of
  // the whole word is safe; a mid-word change is never expected.
  logic fuse_s1_q;
  logic fuse_s2_q;
  logic [ADDR_W-1:0] boot_s1_q;
  logic [ADDR_W-1:0] boot_s2_q;

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      fuse_s1_q <= FUSE_UNPROGRAMMED;
      fuse_s2_q <= FUSE_UNPROGRAMMED;
      boot_s1_q <= RESET_ADDR_APP;
      boot_s2_q <= RESET_ADDR_APP;
    end else if (ce_i) begin
      fuse_s1_q <= boot_reset_select_fuse_i;
      fuse_s2_q <= fuse_s1_q;
      boot_s1_q <= boot_start_i;
      boot_s2_q <= boot_s1_q;
    end
  end

  // ****************************************************************
  // Protected change of the select bit
  // ****************************************************************
  rvm_chg_e chg_q;
  rvm_chg_e chg_d;
  logic [UNLOCK_CNT_W-1:0] cnt_q;
  logic [UNLOCK_CNT_W-1:0] cnt_d;
  logic sel_q;
  logic sel_d;
  logic wr_unlock;

  assign wr_unlock = ctrl_wdata_i[CTRL_UNLOCK_BIT];

  always_comb begin
    chg_d = chg_q;
    cnt_d = cnt_q;
    sel_d = sel_q;
    case (chg_q)
      RVM_CHG_IDLE: begin
        if (ctrl_wr_i && wr_unlock) begin
          chg_d = RVM_CHG_ARMED;
          cnt_d = '0;
        end
      end
      RVM_CHG_ARMED: begin
        // Select only changes when written inside the window with unlock 0
        if (ctrl_wr_i && !wr_unlock) begin
          sel_d = ctrl_wdata_i[CTRL_SELECT_BIT];
          chg_d = RVM_CHG_POST;
        end else if (ctrl_wr_i && wr_unlock) begin
          cnt_d = '0;
        end else if (cnt_q == UNLOCK_LAST) begin
          chg_d = RVM_CHG_IDLE;
        end else begin
          cnt_d = cnt_q + UNLOCK_CNT_W'(1);
        end
      end
      RVM_CHG_POST: begin
        // Hold lasts until the instruction after the select write is done
        if (instr_done_i) begin
          chg_d = RVM_CHG_IDLE;
        end
      end
      default: begin
        chg_d = RVM_CHG_IDLE;
        cnt_d = '0;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      chg_q <= RVM_CHG_IDLE;
      cnt_q <= '0;
      sel_q <= 1'b0;
    end else if (ce_i) begin
      chg_q <= chg_d;
      cnt_q <= cnt_d;
      sel_q <= sel_d;
    end
  end

  // Hold starts combinationally in the cycle the unlock write lands
  assign irq_hold_o = (chg_q != RVM_CHG_IDLE) || (ctrl_wr_i && wr_unlock);
  assign vector_table_select_o = sel_q;
  assign vector_change_unlock_o = (chg_q == RVM_CHG_ARMED);

  // ****************************************************************
  // Placement of reset and table
  // ****************************************************************
  logic [ADDR_W-1:0] reset_addr_d;
  logic [ADDR_W-1:0] reset_addr_q;
  logic [ADDR_W-1:0] base_d;
  logic [ADDR_W-1:0] base_q;

  always_comb begin
    reset_addr_d = RESET_ADDR_APP;
    if (fuse_s2_q == FUSE_PROGRAMMED) begin
      reset_addr_d = boot_s2_q;
    end
    base_d = RESET_ADDR_APP;
    if (sel_q) begin
      base_d = boot_s2_q;
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      reset_addr_q <= RESET_ADDR_APP;
      base_q <= RESET_ADDR_APP;
    end else if (ce_i) begin
      reset_addr_q <= reset_addr_d;
      base_q <= base_d;
    end
  end

  assign reset_addr_o = reset_addr_q;
  assign vec_base_o = rvm_vec_addr(base_q, VEC_NUM_FIRST_IRQ);

  // ****************************************************************
  // Dispatch
  // ****************************************************************
  rvm_prio_if prio ();

  assign prio.req = irq_pend_i;

  rvm_prio u_prio (
    .p (prio.enc)
  );

  logic valid_d;
  logic valid_q;
  logic [VEC_NUM_W-1:0] num_d;
  logic [VEC_NUM_W-1:0] num_q;
  logic [ADDR_W-1:0] addr_d;
  logic [ADDR_W-1:0] addr_q;

  always_comb begin
    valid_d = valid_q;
    num_d = num_q;
    addr_d = addr_q;
    if (irq_ack_i || !valid_q) begin
      // Offer is refreshed after an ack so the next winner is seen
      valid_d = prio.any && global_en_i && !irq_hold_o && !irq_ack_i;
      num_d = prio.num;
      // Offsets table covers all 26 entries, two words apart
      addr_d = rvm_vec_addr(base_d, prio.num);
    end else if (irq_hold_o || !global_en_i) begin
      valid_d = 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      valid_q <= 1'b0;
      num_q <= VEC_NUM_RESET;
      addr_q <= RESET_ADDR_APP;
    end else if (ce_i) begin
      valid_q <= valid_d;
      num_q <= num_d;
      addr_q <= addr_d;
    end
  end

  assign irq_valid_o = valid_q;
  assign irq_num_o = num_q;
  assign irq_addr_o = addr_q;

endmodule : rvm_top

// [verilog/rvm_pkg.sv]
// Package with the constants of the reset and interrupt vector map
package rvm_pkg;

  // ****************************************************************
  // Table shape
  // ****************************************************************
  localparam int VEC_COUNT = 26;
  localparam int IRQ_COUNT = VEC_COUNT - 1;
  localparam int VEC_NUM_W = 5;
  localparam int ADDR_W = 16;
  localparam logic [VEC_NUM_W-1:0] VEC_NUM_RESET = 5'h01;
  localparam logic [VEC_NUM_W-1:0] VEC_NUM_FIRST_IRQ = 5'h02;

  // ****************************************************************
  // Program word addresses of the vectors, application placement
  // ****************************************************************
  localparam logic [ADDR_W-1:0] RESET_ADDR_APP = 16'h0000;
  localparam logic [ADDR_W-1:0] VEC_STRIDE = 16'h0002;
  localparam logic [ADDR_W-1:0] VEC_OFFS [VEC_COUNT] = '{
    16'h0000, 16'h0002, 16'h0004, 16'h0006, 16'h0008, 16'h000A, 16'h000C,
    16'h000E, 16'h0010, 16'h0012, 16'h0014, 16'h0016, 16'h0018, 16'h001A,
    16'h001C, 16'h001E, 16'h0020, 16'h0022, 16'h0024, 16'h0026, 16'h0028,
    16'h002A, 16'h002C, 16'h002E, 16'h0030, 16'h0032
  };

  // ****************************************************************
  // Control bits of the core control register and fuse pin polarity
  // ****************************************************************
  localparam int CTRL_W = 2;
  localparam int CTRL_UNLOCK_BIT = 0;
  localparam int CTRL_SELECT_BIT = 1;
  localparam logic FUSE_PROGRAMMED = 1'b0;
  localparam logic FUSE_UNPROGRAMMED = 1'b1;

  // ****************************************************************
  // Timing, in core clock cycles
  // ****************************************************************
  localparam int UNLOCK_WINDOW_CYC = 4;
  localparam int UNLOCK_CNT_W = 3;
  localparam logic [UNLOCK_CNT_W-1:0] UNLOCK_LAST =
    UNLOCK_CNT_W'(UNLOCK_WINDOW_CYC - 1);

  typedef enum logic [1:0] {
    RVM_CHG_IDLE  = 2'b00,
    RVM_CHG_ARMED = 2'b01,
    RVM_CHG_POST  = 2'b10
  } rvm_chg_e;

  // Program address of vector number num for a given table base
  function automatic logic [ADDR_W-1:0] rvm_vec_addr(
    input logic [ADDR_W-1:0] base,
    input logic [VEC_NUM_W-1:0] num
  );
    logic [ADDR_W-1:0] off;
    off = VEC_OFFS[0];
    if (num != 5'h00 && 32'(num) <= VEC_COUNT) begin
      off = VEC_OFFS[32'(num) - 1];
    end
    return base + off;
  endfunction : rvm_vec_addr

endpackage : rvm_pkg

// [verilog/rvm_prio_if.sv]
// Interface between the vector map and its priority encoder
`timescale 1ns/1ps
interface rvm_prio_if;
  logic [rvm_pkg::IRQ_COUNT-1:0] req;
  logic any;
  logic [rvm_pkg::VEC_NUM_W-1:0] num;
  modport enc (input req, output any, output num);
  modport top (output req, input any, input num);
endinterface : rvm_prio_if

// [verilog/rvm_prio.sv]
// Fixed priority encoder: lowest vector number wins
`timescale 1ns/1ps
module rvm_prio (
  rvm_prio_if.enc p // Pending requests in, winner out
);
  import rvm_pkg::*;

  always_comb begin
    p.any = 1'b0;
    p.num = VEC_NUM_RESET;
    // Scan from the top so the lowest set index is the last to assign
    for (int i = IRQ_COUNT - 1; i >= 0; i--) begin
      if (p.req[i]) begin
        p.any = 1'b1;
        p.num = VEC_NUM_W'(i) + VEC_NUM_FIRST_IRQ;
      end
    end
  end

endmodule : rvm_prio

// [tb/rvm_top_sva.sv]
// Checker of the vector map top ports
`timescale 1ns/1ps
module rvm_top_sva (
  input wire logic ref_clk_i, // Clock
  input wire logic rst_i, // Reset
  input wire logic boot_reset_select_fuse_i, // Fuse
  input wire logic [rvm_pkg::ADDR_W-1:0] boot_start_i, // Boot start
  input wire logic ctrl_wr_i, // Write
  input wire logic [rvm_pkg::CTRL_W-1:0] ctrl_wdata_i, // Data
  input wire logic instr_done_i, // Retire
  input wire logic [rvm_pkg::IRQ_COUNT-1:0] irq_pend_i, // Pending
  input wire logic [rvm_pkg::ADDR_W-1:0] reset_addr_o, // Reset addr
  input wire logic [rvm_pkg::ADDR_W-1:0] vec_base_o, // Base
  input wire logic irq_valid_o, // Offer
  input wire logic [rvm_pkg::VEC_NUM_W-1:0] irq_num_o, // Number
  input wire logic [rvm_pkg::ADDR_W-1:0] irq_addr_o, // Address
  input wire logic irq_hold_o, // Hold
  input wire logic vector_table_select_o, // Select
  input wire logic vector_change_unlock_o // Unlock
);
  logic [4:0] low_num;
  always_comb begin
    low_num = 5'h00;
    for (int i = 24; i >= 0; i--) begin
      if (irq_pend_i[i]) begin
        low_num = 5'(i + 2);
      end
    end
  end
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  a_reset_addr: assert property (
    (!rst_i && $stable(boot_reset_select_fuse_i) && $stable(boot_start_i))[*4] |->
    reset_addr_o == (boot_reset_select_fuse_i ? 16'h0000 : boot_start_i)) else $error("reset addr");
  a_base_app: assert property (
    (!vector_table_select_o)[*2] |-> vec_base_o == 16'h0002) else $error("app base");
  a_base_boot: assert property (
    (vector_table_select_o && $stable(boot_start_i))[*4] |->
    vec_base_o == boot_start_i + 16'h0002) else $error("boot base");
  a_offer_addr: assert property (
    irq_valid_o && $stable(vector_table_select_o) |-> irq_addr_o ==
    (vector_table_select_o ? boot_start_i : 16'h0000) + {10'h000, irq_num_o - 5'h01, 1'b0})
    else $error("offer addr");
  a_num_range: assert property (
    irq_valid_o |-> irq_num_o >= 5'h02 && irq_num_o <= 5'h1A) else $error("num range");
  a_lowest_first: assert property (
    $rose(irq_valid_o) |-> irq_num_o == $past(low_num)) else $error("not lowest");
  a_hold_blocks: assert property (
    irq_hold_o |=> !irq_valid_o) else $error("offer in hold");
  a_unlock_stands: assert property (
    ctrl_wr_i && ctrl_wdata_i == 2'b01 ##1 (!ctrl_wr_i)[*4] |-> vector_change_unlock_o)
    else $error("unlock short");
  a_unlock_expire: assert property (
    $rose(vector_change_unlock_o) ##0 (!ctrl_wr_i)[*4] |=> !vector_change_unlock_o)
    else $error("unlock long");
  a_select_write: assert property (
    ctrl_wr_i && vector_change_unlock_o && !ctrl_wdata_i[0] |=>
    vector_table_select_o == $past(ctrl_wdata_i[1]) && !vector_change_unlock_o)
    else $error("select write");
  a_select_guard: assert property (
    $changed(vector_table_select_o) |-> $past(ctrl_wr_i) && $past(vector_change_unlock_o))
    else $error("select unguarded");
  a_hold_release: assert property (
    irq_hold_o && !vector_change_unlock_o && instr_done_i && !ctrl_wr_i |=> !irq_hold_o)
    else $error("hold stuck");
endmodule : rvm_top_sva
bind rvm_top rvm_top_sva i_rvm_top_sva (.ref_clk_i, .rst_i, .boot_reset_select_fuse_i,
  .boot_start_i, .ctrl_wr_i, .ctrl_wdata_i, .instr_done_i, .irq_pend_i, .reset_addr_o,
  .vec_base_o, .irq_valid_o, .irq_num_o, .irq_addr_o, .irq_hold_o, .vector_table_select_o,
  .vector_change_unlock_o);

// [tb/rvm_core_model.sv]
// Core model that takes offered vectors after a set wait
`timescale 1ns/1ps
module rvm_core_model (
  input wire logic clk_i, // Core clock
  input wire logic rst_i, // Reset
  input wire logic valid_i, // Vector offered
  input wire logic [4:0] num_i, // Offered number
  input wire logic [1:0] dly_i, // Wait before taking
  output logic ack_o, // Take pulse
  output logic [4:0] got_num_o // Last number taken
);
  logic [1:0] cnt_q;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      cnt_q <= 2'b00;
      got_num_o <= 5'h00;
    end else if (ack_o) begin
      // Only one take per offer; the offer is gone after this edge
      ack_o <= 1'b0;
      got_num_o <= num_i;
    end else if (valid_i && cnt_q == dly_i) begin
      ack_o <= 1'b1;
      cnt_q <= 2'b00;
    end else begin
      cnt_q <= valid_i ? cnt_q + 2'b01 : 2'b00;
    end
  end
endmodule : rvm_core_model

// [tb/tb.sv]
// Testbench of the reset and interrupt vector map
`timescale 1ns/1ps
module tb;
  import rvm_pkg::*;
  logic ref_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic ce_i = 1'b1;
  logic boot_reset_select_fuse_i = 1'b1;
  logic [ADDR_W-1:0] boot_start_i = 16'h3C00;
  logic ctrl_wr_i = 1'b0;
  logic [CTRL_W-1:0] ctrl_wdata_i = 2'b00;
  logic instr_done_i = 1'b0;
  logic global_en_i = 1'b1;
  logic [IRQ_COUNT-1:0] irq_pend_i = '0;
  logic irq_ack_i, irq_valid_o, irq_hold_o, vector_table_select_o, vector_change_unlock_o;
  logic [ADDR_W-1:0] reset_addr_o, vec_base_o, irq_addr_o;
  logic [VEC_NUM_W-1:0] irq_num_o, got_num;
  logic [1:0] dly = 2'b00;
  int mismatches = 0;
  int samples_checked = 0;
  int cyc = 0;
  localparam logic [15:0] EXP [26] = '{16'h0000, 16'h0002, 16'h0004, 16'h0006, 16'h0008,
    16'h000A, 16'h000C, 16'h000E, 16'h0010, 16'h0012, 16'h0014, 16'h0016, 16'h0018, 16'h001A,
    16'h001C, 16'h001E, 16'h0020, 16'h0022, 16'h0024, 16'h0026, 16'h0028, 16'h002A, 16'h002C,
    16'h002E, 16'h0030, 16'h0032};
  rvm_top i_rvm_top (.ref_clk_i, .rst_i, .ce_i, .boot_reset_select_fuse_i, .boot_start_i,
    .ctrl_wr_i, .ctrl_wdata_i, .instr_done_i, .global_en_i, .irq_pend_i, .irq_ack_i,
    .reset_addr_o, .vec_base_o, .irq_valid_o, .irq_num_o, .irq_addr_o, .irq_hold_o,
    .vector_table_select_o, .vector_change_unlock_o);
  rvm_core_model i_rvm_core_model (.clk_i(ref_clk_i), .rst_i, .valid_i(irq_valid_o),
    .num_i(irq_num_o), .dly_i(dly), .ack_o(irq_ack_i), .got_num_o(got_num));
  always #50 ref_clk_i = ~ref_clk_i;
  always @(posedge ref_clk_i) begin
    cyc++;
    if (cyc == 3000) begin
      mismatches++;
      report_and_stop();
    end
  end
  task automatic tick;
    @(posedge ref_clk_i);
    #1;
  endtask : tick
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [1:0] d);
    ctrl_wr_i = 1'b1;
    ctrl_wdata_i = d;
    tick();
    ctrl_wr_i = 1'b0;
    tick();
  endtask : wr
  task automatic take(input logic [4:0] n, input logic [15:0] a);
    while (irq_valid_o !== 1'b1) tick();
    chk("irq_num_o", 16'(n), 16'(irq_num_o));
    chk("irq_addr_o", a, irq_addr_o);
    irq_pend_i = '0;
    while (irq_valid_o !== 1'b0) tick();
    chk("got_num", 16'(n), 16'(got_num));
  endtask : take
  task automatic run_table(input logic [15:0] base);
    for (int n = 1; n < 26; n++) begin
      dly = 2'(n);
      // A low-priority request rides along to prove the lowest number wins
      irq_pend_i = 25'h100_0000 | (25'h1 << (n - 1));
      take(5'(n + 1), base + EXP[n]);
    end
  endtask : run_table
  task automatic do_reset;
    rst_i = 1'b1;
    repeat (5) tick();
    chk("reset_addr_o", 16'h0000, reset_addr_o);
    chk("vec_base_o", 16'h0002, vec_base_o);
    rst_i = 1'b0;
    repeat (4) tick();
    chk("reset_addr_o", boot_reset_select_fuse_i ? 16'h0000 : boot_start_i, reset_addr_o);
  endtask : do_reset
  task automatic report_and_stop;
    if (mismatches == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : report_and_stop
  initial begin
    do_reset();
    run_table(16'h0000);
    wr(2'b01);
    chk("unlock", 16'h0001, 16'(vector_change_unlock_o));
    chk("hold", 16'h0001, 16'(irq_hold_o));
    irq_pend_i = 25'h000_0020;
    wr(2'b10);
    chk("select", 16'h0001, 16'(vector_table_select_o));
    chk("unlock", 16'h0000, 16'(vector_change_unlock_o));
    chk("vec_base_o", 16'h3C02, vec_base_o);
    chk("valid", 16'h0000, 16'(irq_valid_o));
    instr_done_i = 1'b1;
    tick();
    instr_done_i = 1'b0;
    tick();
    chk("hold", 16'h0000, 16'(irq_hold_o));
    take(5'h07, 16'h3C0C);
    run_table(16'h3C00);
    wr(2'b01);
    repeat (5) tick();
    wr(2'b00);
    chk("select", 16'h0001, 16'(vector_table_select_o));
    boot_reset_select_fuse_i = 1'b0;
    do_reset();
    global_en_i = 1'b0;
    irq_pend_i = 25'h000_0001;
    repeat (3) tick();
    chk("valid", 16'h0000, 16'(irq_valid_o));
    global_en_i = 1'b1;
    take(5'h02, 16'h0002);
    // Clock enable low must freeze the offer even with a request pending
    ce_i = 1'b0;
    irq_pend_i = 25'h000_0004;
    repeat (3) tick();
    chk("valid", 16'h0000, 16'(irq_valid_o));
    ce_i = 1'b1;
    take(5'h04, 16'h0006);
    report_and_stop();
  end
endmodule : tb
